// *** exec_map.svh ***
// constant map for the arithmetic, compare, skip and branch execution unit
//
// Summary of operation
// - word add immediate: flags ZCNVS, two cycles
// - multiplies write R1:R0, flags Z C, two cycles
// - compare-skip-equal skips next, no flags, 1-3 cycles
// - compares set six flags, write nothing, one cycle
// - indirect call/jump load Z, clear high bits
// - signed ge branch when N xor V is 0
// - signed lt branch when N xor V is 1
// - overflow-clear branch taken only when V is 0
// - io-bit-clear skip tests low io bit, no flags
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH

// =============================================================
// status flag bit positions
`define FLG_C 3'h0
`define FLG_Z 3'h1
`define FLG_N 3'h2
`define FLG_V 3'h3
`define FLG_S 3'h4
`define FLG_H 3'h5
`define FLG_T 3'h6
`define FLG_I 3'h7
`define FLAGS_RST 8'h00

// =============================================================
// cycle counts
`define CYC_ALU    2'h1
`define CYC_WORD   2'h2
`define CYC_MUL    2'h2
`define CYC_JUMP   2'h2
`define CYC_BR_NT  2'h1
`define CYC_BR_TK  2'h2
`define CYC_SKIP_1 2'h2
`define CYC_SKIP_2 2'h3

// =============================================================
// program counter steps and constants
`define PC_STEP    2'h1
`define SKIP_ONE   2'h2
`define SKIP_TWO   2'h3
`define BYTE_ONES  8'hFF
`define BYTE_ZERO  8'h00
`define BYTE_ONE   8'h01

`endif

// *** exec_pkg.sv ***
// types shared by the execution unit
package exec_pkg;

    typedef enum logic [4:0] {
        OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_EOR, OP_COM,
        OP_NEG, OP_INC, OP_DEC, OP_SER, OP_ADD_IMM_WORD, OP_SUB_IMM_WORD,
        OP_MUL_UU, OP_MUL_SS, OP_MULT_SIGNED_BY_UNSIGNED,
        OP_FRACTIONAL_PRODUCT, OP_FRAC_SS, OP_FRAC_SU,
        OP_CMP, OP_CMP_CARRY, OP_COMPARE_SKIP_EQUAL,
        OP_INDIRECT_JUMP_OP, OP_INDIRECT_SUBROUTINE_CALL,
        OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT, OP_BRANCH_NO_OVERFLOW,
        OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLR, OP_SKIP_IO_BIT_CLEAR
    } op_t;

    typedef enum logic [1:0] {
        DEST_NONE = 2'h0,
        DEST_RD   = 2'h1,
        DEST_PAIR = 2'h2,
        DEST_R1R0 = 2'h3
    } dest_t;

    // gray along idle -> wait
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1
    } state_t;

    typedef struct packed {
        op_t         op;
        logic [7:0]  rd;        // first operand
        logic [7:0]  rr;        // register or immediate operand
        logic [15:0] word;      // register pair value
        logic [5:0]  kimm;      // word immediate
        logic [6:0]  koff;      // signed branch offset
        logic [15:0] zptr;
        logic [7:0]  io_byte;   // selected low io register
        logic [2:0]  bit_sel;   // io bit or status bit
        logic        next_two_word;
    } issue_t;

endpackage : exec_pkg

// *** add8_flags.sv ***
// 8-bit add/subtract with carry, half-carry and overflow
`timescale 1ns/100ps
`default_nettype none
module add8_flags (
    // operands
    input  wire logic       a,
    input  wire logic [7:0] av,
    input  wire logic [7:0] bv,
    input  wire logic       cin,
    input  wire logic       sub,
    // results
    output logic [7:0]      sum,
    output logic            c,
    output logic            h,
    output logic            v
);
    logic [7:0] cb;

    always_comb begin
        if (sub) begin
            sum = av - bv - {7'h00, cin};
            cb  = (~av & bv) | (bv & sum) | (sum & ~av);
            v   = (av[7] & ~bv[7] & ~sum[7]) | (~av[7] & bv[7] & sum[7]);
        end else begin
            sum = av + bv + {7'h00, cin};
            cb  = (av & bv) | (bv & ~sum) | (~sum & av);
            v   = (av[7] & bv[7] & ~sum[7]) | (~av[7] & ~bv[7] & sum[7]);
        end
        c = cb[7] & a;
        h = cb[3] & a;
    end
endmodule : add8_flags
`default_nettype wire

// *** cpu_alu_branch_exec.sv ***
// execution unit for arithmetic, multiply, compare, skip, call and branch operations
`timescale 1ns/100ps
`default_nettype none
`include "exec_map.svh"
module cpu_alu_branch_exec
    import exec_pkg::*;
#(
    parameter int PC_W        = 22,
    parameter int CALL_CYCLES = 2
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // instruction issue
    input  wire logic             issue_valid,
    input  wire issue_t           issue,
    // direct status write
    input  wire logic             status_wr,
    input  wire logic [7:0]       status_wdata,
    // results
    output logic                  busy_ff,
    output logic                  done_ff,
    output var dest_t             dest_ff,
    output logic [15:0]           result_ff,
    output logic [7:0]            status_flags_ff,
    output logic [PC_W-1:0]       pc_ff,
    output logic [PC_W-1:0]       ret_addr_ff,
    output logic                  push_ret_ff
);
    // =========================================================
    // byte adder
    logic       add_sub;
    logic       add_cin;
    logic       add_flagged;
    logic [7:0] add_a;
    logic [7:0] add_b;
    logic [7:0] add_sum;
    logic       add_c;
    logic       add_h;
    logic       add_v;

    add8_flags u_add (
        .a   (add_flagged),
        .av  (add_a),
        .bv  (add_b),
        .cin (add_cin),
        .sub (add_sub),
        .sum (add_sum),
        .c   (add_c),
        .h   (add_h),
        .v   (add_v)
    );

    // =========================================================
    // operand shaping
    logic        accept;
    logic [7:0]  fl;
    logic [16:0] wsum;
    logic [17:0] prod;
    logic [15:0] prod_out;
    logic        sign_a;
    logic        sign_b;
    logic        frac;
    logic        nv;
    logic        cond;
    logic [PC_W-1:0] pc_next;
    logic [PC_W-1:0] pc_rel;
    logic [PC_W-1:0] pc_skip;

    assign accept  = issue_valid & ~busy_ff;
    assign fl      = status_flags_ff;
    assign nv      = fl[`FLG_N] ^ fl[`FLG_V];
    assign pc_next = pc_ff + PC_W'(`PC_STEP);
    assign pc_rel  = pc_next + {{(PC_W-7){issue.koff[6]}}, issue.koff};
    // skipped instruction length picks the distance
    assign pc_skip = pc_ff + (issue.next_two_word ? PC_W'(`SKIP_TWO) : PC_W'(`SKIP_ONE));

    always_comb begin
        add_a       = issue.rd;
        add_b       = issue.rr;
        add_cin     = 1'b0;
        add_sub     = 1'b0;
        add_flagged = 1'b1;
        case (issue.op)
            OP_ADC: begin
                add_cin = fl[`FLG_C];
            end
            OP_SUB, OP_CMP: begin
                add_sub = 1'b1;
            end
            OP_SBC, OP_CMP_CARRY: begin
                add_sub = 1'b1;
                add_cin = fl[`FLG_C];
            end
            OP_NEG: begin
                add_a   = `BYTE_ZERO;
                add_b   = issue.rd;
                add_sub = 1'b1;
            end
            OP_INC: begin
                add_b = `BYTE_ONE;
            end
            OP_DEC: begin
                add_b   = `BYTE_ONE;
                add_sub = 1'b1;
            end
            default: begin
                add_flagged = 1'b1;
            end
        endcase
    end

    // word add/subtract of a small constant
    always_comb begin
        if (issue.op == OP_SUB_IMM_WORD) begin
            wsum = {1'b0, issue.word} - {11'h000, issue.kimm};
        end else begin
            wsum = {1'b0, issue.word} + {11'h000, issue.kimm};
        end
    end

    // one 9x9 signed multiplier covers all signedness variants
    always_comb begin
        sign_a = 1'b0;
        sign_b = 1'b0;
        frac   = 1'b0;
        case (issue.op)
            OP_MUL_SS, OP_FRAC_SS: begin
                sign_a = 1'b1;
                sign_b = 1'b1;
            end
            OP_MULT_SIGNED_BY_UNSIGNED, OP_FRAC_SU: begin
                sign_a = 1'b1;
            end
            default: begin
                sign_a = 1'b0;
            end
        endcase
        if (issue.op == OP_FRACTIONAL_PRODUCT || issue.op == OP_FRAC_SS
                || issue.op == OP_FRAC_SU) begin
            frac = 1'b1;
        end
        prod = 18'($signed({sign_a & issue.rd[7], issue.rd})
                 * $signed({sign_b & issue.rr[7], issue.rr}));
        prod_out = frac ? {prod[14:0], 1'b0} : prod[15:0];
    end

    // =========================================================
    // per-instruction result, flags, pc and cycle count
    dest_t           nxt_dest;
    logic [15:0]     nxt_result;
    logic [7:0]      nxt_flags;
    logic [PC_W-1:0] nxt_pc;
    logic [1:0]      op_cycles;
    logic            op_push;

    always_comb begin
        nxt_dest   = DEST_NONE;
        nxt_result = 16'h0000;
        nxt_flags  = fl;
        nxt_pc     = pc_next;
        op_cycles  = `CYC_ALU;
        op_push    = 1'b0;
        cond       = 1'b0;
        case (issue.op)
            OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_NEG, OP_CMP, OP_CMP_CARRY: begin
                if (issue.op != OP_CMP && issue.op != OP_CMP_CARRY) begin
                    nxt_dest   = DEST_RD;
                    nxt_result = {8'h00, add_sum};
                end
                // compares only update flags, one cycle
                nxt_flags[`FLG_C] = add_c;
                nxt_flags[`FLG_H] = add_h;
                nxt_flags[`FLG_V] = add_v;
                nxt_flags[`FLG_N] = add_sum[7];
                nxt_flags[`FLG_S] = add_sum[7] ^ add_v;
                nxt_flags[`FLG_Z] = (add_sum == `BYTE_ZERO);
                // subtract-with-carry and compare-with-carry only keep zero across bytes
                if (issue.op == OP_SBC || issue.op == OP_CMP_CARRY) begin
                    nxt_flags[`FLG_Z] = (add_sum == `BYTE_ZERO) & fl[`FLG_Z];
                end
            end
            OP_INC, OP_DEC: begin
                nxt_dest          = DEST_RD;
                nxt_result        = {8'h00, add_sum};
                nxt_flags[`FLG_V] = add_v;
                nxt_flags[`FLG_N] = add_sum[7];
                nxt_flags[`FLG_S] = add_sum[7] ^ add_v;
                nxt_flags[`FLG_Z] = (add_sum == `BYTE_ZERO);
            end
            OP_AND, OP_OR, OP_EOR, OP_COM: begin
                nxt_dest = DEST_RD;
                case (issue.op)
                    OP_AND:  nxt_result = {8'h00, issue.rd & issue.rr};
                    OP_OR:   nxt_result = {8'h00, issue.rd | issue.rr};
                    OP_EOR:  nxt_result = {8'h00, issue.rd ^ issue.rr};
                    default: nxt_result = {8'h00, `BYTE_ONES - issue.rd};
                endcase
                nxt_flags[`FLG_V] = 1'b0;
                nxt_flags[`FLG_N] = nxt_result[7];
                nxt_flags[`FLG_S] = nxt_result[7];
                nxt_flags[`FLG_Z] = (nxt_result[7:0] == `BYTE_ZERO);
                if (issue.op == OP_COM) begin
                    nxt_flags[`FLG_C] = 1'b1;
                end
            end
            OP_SER: begin
                nxt_dest   = DEST_RD;
                nxt_result = {8'h00, `BYTE_ONES};
            end
            OP_ADD_IMM_WORD, OP_SUB_IMM_WORD: begin
                nxt_dest   = DEST_PAIR;
                nxt_result = wsum[15:0];
                op_cycles  = `CYC_WORD;
                if (issue.op == OP_ADD_IMM_WORD) begin
                    nxt_flags[`FLG_C] = wsum[16];
                    nxt_flags[`FLG_V] = ~issue.word[15] & wsum[15];
                end else begin
                    nxt_flags[`FLG_C] = wsum[15] & ~issue.word[15];
                    nxt_flags[`FLG_V] = issue.word[15] & ~wsum[15];
                end
                nxt_flags[`FLG_N] = wsum[15];
                nxt_flags[`FLG_S] = wsum[15] ^ nxt_flags[`FLG_V];
                nxt_flags[`FLG_Z] = (wsum[15:0] == 16'h0000);
            end
            OP_MUL_UU, OP_MUL_SS, OP_MULT_SIGNED_BY_UNSIGNED,
            OP_FRACTIONAL_PRODUCT, OP_FRAC_SS, OP_FRAC_SU: begin
                nxt_dest          = DEST_R1R0;
                nxt_result        = prod_out;
                nxt_flags[`FLG_C] = prod[15];
                nxt_flags[`FLG_Z] = (prod_out == 16'h0000);
                op_cycles         = `CYC_MUL;
            end
            OP_COMPARE_SKIP_EQUAL, OP_SKIP_IO_BIT_CLEAR: begin
                if (issue.op == OP_COMPARE_SKIP_EQUAL) begin
                    cond = (issue.rd == issue.rr);
                end else begin
                    cond = ~issue.io_byte[issue.bit_sel];
                end
                if (cond) begin
                    nxt_pc    = pc_skip;
                    op_cycles = issue.next_two_word ? `CYC_SKIP_2 : `CYC_SKIP_1;
                end
            end
            OP_INDIRECT_JUMP_OP, OP_INDIRECT_SUBROUTINE_CALL: begin
                nxt_pc    = {{(PC_W-16){1'b0}}, issue.zptr};
                op_cycles = `CYC_JUMP;
                if (issue.op == OP_INDIRECT_SUBROUTINE_CALL) begin
                    op_push   = 1'b1;
                    op_cycles = 2'(CALL_CYCLES);
                end
            end
            OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT, OP_BRANCH_NO_OVERFLOW,
            OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLR: begin
                case (issue.op)
                    OP_BRANCH_SIGNED_GE:   cond = ~nv;
                    OP_BRANCH_SIGNED_LT:   cond = nv;
                    OP_BRANCH_NO_OVERFLOW: cond = ~fl[`FLG_V];
                    OP_BRANCH_FLAG_SET:    cond = fl[issue.bit_sel];
                    default:               cond = ~fl[issue.bit_sel];
                endcase
                op_cycles = `CYC_BR_NT;
                if (cond) begin
                    nxt_pc    = pc_rel;
                    op_cycles = `CYC_BR_TK;
                end
            end
            default: begin
                nxt_dest = DEST_NONE;
            end
        endcase
    end

    // =========================================================
    // sequencing: outputs land at accept, done at the last cycle
    state_t          state_ff;
    state_t          nxt_state;
    logic [1:0]      cnt_ff;
    logic [1:0]      nxt_cnt;
    logic            nxt_done;
    dest_t           nxt_dest_q;
    logic [15:0]     nxt_result_q;
    logic [7:0]      nxt_flags_q;
    logic [PC_W-1:0] nxt_pc_q;
    logic [PC_W-1:0] nxt_ret;
    logic            nxt_push;

    always_comb begin
        nxt_state    = state_ff;
        nxt_cnt      = cnt_ff;
        nxt_done     = 1'b0;
        nxt_dest_q   = dest_ff;
        nxt_result_q = result_ff;
        nxt_flags_q  = status_flags_ff;
        nxt_pc_q     = pc_ff;
        nxt_ret      = ret_addr_ff;
        nxt_push     = 1'b0;
        // instruction update wins over a direct status write
        if (status_wr) begin
            nxt_flags_q = status_wdata;
        end
        case (state_ff)
            ST_IDLE: begin
                if (accept) begin
                    nxt_dest_q   = nxt_dest;
                    nxt_result_q = nxt_result;
                    nxt_flags_q  = nxt_flags;
                    nxt_pc_q     = nxt_pc;
                    nxt_push     = op_push;
                    if (op_push) begin
                        nxt_ret = pc_next;
                    end
                    if (op_cycles == `CYC_ALU) begin
                        nxt_done = 1'b1;
                    end else begin
                        nxt_state = ST_WAIT;
                        nxt_cnt   = op_cycles - 2'h2;
                    end
                end
            end
            ST_WAIT: begin
                if (cnt_ff == 2'h0) begin
                    nxt_done  = 1'b1;
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 2'h1;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff        <= ST_IDLE;
            cnt_ff          <= 2'h0;
            busy_ff         <= 1'b0;
            done_ff         <= 1'b0;
            dest_ff         <= DEST_NONE;
            result_ff       <= 16'h0000;
            status_flags_ff <= `FLAGS_RST;
            pc_ff           <= '0;
            ret_addr_ff     <= '0;
            push_ret_ff     <= 1'b0;
        end else begin
            state_ff        <= nxt_state;
            cnt_ff          <= nxt_cnt;
            busy_ff         <= (nxt_state == ST_WAIT);
            done_ff         <= nxt_done;
            dest_ff         <= nxt_dest_q;
            result_ff       <= nxt_result_q;
            status_flags_ff <= nxt_flags_q;
            pc_ff           <= nxt_pc_q;
            ret_addr_ff     <= nxt_ret;
            push_ret_ff     <= nxt_push;
        end
    end
endmodule : cpu_alu_branch_exec
`default_nettype wire

// *** exec_assertions.sv ***
// concurrent checks on the execution unit ports
`timescale 1ns/100ps
`default_nettype none
module exec_assertions
    import exec_pkg::*;
#(
    parameter int PC_W = 22
) (
    // clock, reset and issue
    input wire logic            clk,
    input wire logic            rst,
    input wire logic            issue_valid,
    input wire issue_t          issue,
    input wire logic            status_wr,
    // results
    input wire logic            busy_ff,
    input wire logic            done_ff,
    input wire dest_t           dest_ff,
    input wire logic [15:0]     result_ff,
    input wire logic [7:0]      status_flags_ff,
    input wire logic [PC_W-1:0] pc_ff
);
    // ==========
    // helpers
    // status write in the accept cycle is left out: it muddles flag checks
    wire            acc    = issue_valid && !busy_ff && !status_wr;
    wire            nv     = status_flags_ff[2] ^ status_flags_ff[3];
    wire [7:0]      sum8   = issue.rd + issue.rr;
    wire [PC_W-1:0] pc_nx  = pc_ff + 1'b1;
    wire [PC_W-1:0] pc_sk3 = pc_ff + 2'h3;
    wire [PC_W-1:0] pc_br  = pc_ff + {{(PC_W-7){issue.koff[6]}}, issue.koff} + 1'b1;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_one;
        done_ff && !busy_ff;
    endsequence
    sequence s_two;
        busy_ff ##1 (!busy_ff && done_ff);
    endsequence
    sequence s_three;
        busy_ff [*2] ##1 (!busy_ff && done_ff);
    endsequence

    // ==========
    // properties
    property p_word;
        acc && issue.op == OP_ADD_IMM_WORD |=> result_ff == $past(issue.word) + $past(issue.kimm)
            && status_flags_ff[5] == $past(status_flags_ff[5]) ##0 s_two;
    endproperty
    property p_mul;
        acc && issue.op inside {OP_MUL_UU, OP_MUL_SS, OP_MULT_SIGNED_BY_UNSIGNED,
            OP_FRACTIONAL_PRODUCT, OP_FRAC_SS, OP_FRAC_SU} |=> dest_ff == DEST_R1R0
            && status_flags_ff[7:2] == $past(status_flags_ff[7:2])
            && status_flags_ff[1] == (result_ff == 16'h0000) ##0 s_two;
    endproperty
    property p_compare_skip_equal;
        acc && issue.op == OP_COMPARE_SKIP_EQUAL && issue.rd == issue.rr && !issue.next_two_word
            |=> pc_ff == $past(pc_nx) + 1'b1 && $stable(status_flags_ff) ##0 s_two;
    endproperty
    property p_cmp;
        acc && issue.op == OP_CMP |=> dest_ff == DEST_NONE
            && status_flags_ff[1] == ($past(issue.rd) == $past(issue.rr)) ##0 s_one;
    endproperty
    property p_indirect_jump_op;
        acc && issue.op == OP_INDIRECT_JUMP_OP |=> pc_ff == {{(PC_W-16){1'b0}}, $past(issue.zptr)}
            && $stable(status_flags_ff) ##0 s_two;
    endproperty
    property p_ge;
        acc && issue.op == OP_BRANCH_SIGNED_GE && !nv |=> pc_ff == $past(pc_br) ##0 s_two;
    endproperty
    property p_lt;
        acc && issue.op == OP_BRANCH_SIGNED_LT && !nv |=> pc_ff == $past(pc_nx) ##0 s_one;
    endproperty
    property p_vc;
        acc && issue.op == OP_BRANCH_NO_OVERFLOW |=> $stable(status_flags_ff)
            && pc_ff == ($past(status_flags_ff[3]) ? $past(pc_nx) : $past(pc_br));
    endproperty
    property p_skip_io_bit_clear;
        acc && issue.op == OP_SKIP_IO_BIT_CLEAR && issue.io_byte[issue.bit_sel]
            |=> pc_ff == $past(pc_nx) && $stable(status_flags_ff) ##0 s_one;
    endproperty
    property p_add;
        acc && issue.op == OP_ADD |=> result_ff == {8'h00, $past(sum8)} ##0 s_one;
    endproperty
    property p_skip3;
        acc && issue.op == OP_COMPARE_SKIP_EQUAL && issue.rd == issue.rr && issue.next_two_word
            |=> pc_ff == $past(pc_sk3) ##0 s_three;
    endproperty

    a_word:  assert property (p_word)  else $error("word add result or timing off");
    a_mul:   assert property (p_mul)   else $error("multiply dest, flags or timing off");
    a_compare_skip_equal:  assert property (p_compare_skip_equal)  else $error("equal skip off");
    a_cmp:   assert property (p_cmp)   else $error("compare wrote or bad zero");
    a_indirect_jump_op:  assert property (p_indirect_jump_op)  else $error("indirect jump target off");
    a_ge:    assert property (p_ge)    else $error("signed ge branch off");
    a_lt:    assert property (p_lt)    else $error("signed lt fall through off");
    a_vc:    assert property (p_vc)    else $error("overflow clear branch off");
    a_skip_io_bit_clear:  assert property (p_skip_io_bit_clear)  else $error("io bit skip off");
    a_add:   assert property (p_add)   else $error("add result or timing off");
    a_skip3: assert property (p_skip3) else $error("two word skip off");
endmodule : exec_assertions
`default_nettype wire

// *** test_cpu_alu_branch_exec.sv ***
// self-checking bench for the execution unit
`timescale 1ns/100ps
`default_nettype none
module test_cpu_alu_branch_exec
    import exec_pkg::*;
;
    // ==========
    // stimulus, outputs and tables
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        issue_valid = 1'b0;
    issue_t      issue = '0;
    issue_t      ins = '0;
    logic        status_wr = 1'b0;
    logic [7:0]  status_wdata = 8'h00;
    logic        busy_ff, done_ff, push_ret_ff, push_seen;
    dest_t       dest_ff;
    logic [15:0] result_ff;
    logic [7:0]  status_flags_ff, ef;
    logic [21:0] pc_ff, ret_addr_ff, epc;
    int          num_errors = 0;
    int          n_compared = 0;
    op_t         alu_op [12] = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_EOR, OP_COM, OP_NEG, OP_INC,
                                 OP_DEC, OP_SER, OP_ADC, OP_SBC};
    // byte i of each table sits at bits 8i+7:8i; the last two run with carry set
    logic [95:0] alu_a = 96'h107F00007F010FFF80F0107F;
    logic [95:0] alu_b = 96'h0F0000000000000F010F2001;
    logic [95:0] alu_r = 96'h0080FFFF80FFF0F08100F080;
    logic [95:0] alu_f = 96'h202C00140C3515141402152C;
    op_t         mul_op [6] = '{OP_MUL_UU, OP_MUL_SS, OP_MULT_SIGNED_BY_UNSIGNED,
                                OP_FRACTIONAL_PRODUCT, OP_FRAC_SS, OP_FRAC_SU};
    logic [15:0] mul_r [6] = '{16'hFE01, 16'h0001, 16'hFF01, 16'hFC02, 16'h0002, 16'hFE02};
    logic [5:0]  mul_c = 6'h2D;
    op_t         br_op [6] = '{OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
                               OP_BRANCH_SIGNED_LT, OP_BRANCH_NO_OVERFLOW, OP_BRANCH_NO_OVERFLOW};
    logic [7:0]  br_f [6] = '{8'h0C, 8'h04, 8'h04, 8'h0C, 8'h04, 8'h08};
    logic [5:0]  br_tk = 6'h15;
    op_t         sk_op [6] = '{OP_COMPARE_SKIP_EQUAL, OP_COMPARE_SKIP_EQUAL, OP_COMPARE_SKIP_EQUAL,
                               OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_CLEAR};
    logic [7:0]  sk_a [6] = '{8'h01, 8'h33, 8'h33, 8'h00, 8'h00, 8'h00};
    logic [7:0]  sk_b [6] = '{8'h02, 8'h33, 8'h33, 8'h02, 8'h03, 8'h03};
    logic [5:0]  sk_two = 6'h24;
    int          sk_d [6] = '{1, 2, 3, 1, 2, 3};

    always #20 clk = ~clk;

    cpu_alu_branch_exec #(.PC_W(22), .CALL_CYCLES(2)) u_cpu_alu_branch_exec (
        .clk(clk), .rst(rst), .issue_valid(issue_valid), .issue(issue),
        .status_wr(status_wr), .status_wdata(status_wdata), .busy_ff(busy_ff),
        .done_ff(done_ff), .dest_ff(dest_ff), .result_ff(result_ff),
        .status_flags_ff(status_flags_ff), .pc_ff(pc_ff), .ret_addr_ff(ret_addr_ff),
        .push_ret_ff(push_ret_ff)
    );

    // ==========
    // tasks
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task set_flags(input logic [7:0] v);
        @(negedge clk);
        status_wr = 1'b1;
        status_wdata = v;
        @(negedge clk);
        status_wr = 1'b0;
        ef = v;
        chk("flags write", status_flags_ff, ef);
    endtask : set_flags

    // one instruction; checks cycle count, pc and flags against the expected ecyc, epc and ef
    task go(input op_t op, input logic [7:0] a, input logic [7:0] b, input int ecyc);
        int n;
        @(negedge clk);
        ins.op = op;
        ins.rd = a;
        ins.rr = b;
        issue = ins;
        issue_valid = 1'b1;
        @(negedge clk);
        issue_valid = 1'b0;
        push_seen = push_ret_ff;
        n = 1;
        while (done_ff !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        if (n == 8) begin
            num_errors++;
            give_verdict();
        end
        chk("cycles", n, ecyc);
        chk("pc", pc_ff, epc);
        chk("flags", status_flags_ff, ef);
    endtask : go

    // ==========
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        epc = '0;
        chk("reset state", {busy_ff, done_ff, push_ret_ff, dest_ff, status_flags_ff, result_ff}, 0);
        chk("reset pc", {pc_ff, ret_addr_ff[9:0]}, 0);
        for (int i = 0; i < 12; i++) begin
            set_flags({7'h00, i > 9});
            ef = alu_f[8*i +: 8];
            epc = epc + 1'b1;
            go(alu_op[i], alu_a[8*i +: 8], alu_b[8*i +: 8], 1);
            chk("alu result", {dest_ff, result_ff}, {DEST_RD, 8'h00, alu_r[8*i +: 8]});
        end
        $display("alu ops done");
        set_flags(8'h20);
        ins.word = 16'hFFFF;
        ins.kimm = 6'h01;
        ef = 8'h23;
        epc = epc + 1'b1;
        go(OP_ADD_IMM_WORD, 8'h00, 8'h00, 2);
        chk("word result", {dest_ff, result_ff}, {DEST_PAIR, 16'h0000});
        ins.word = 16'h0000;
        ef = 8'h35;
        epc = epc + 1'b1;
        go(OP_SUB_IMM_WORD, 8'h00, 8'h00, 2);
        chk("word result", result_ff, 16'hFFFF);
        $display("word ops done");
        set_flags(8'h3C);
        for (int i = 0; i < 6; i++) begin
            ef = {7'h1E, mul_c[i]};
            epc = epc + 1'b1;
            go(mul_op[i], 8'hFF, 8'hFF, 2);
            chk("product", {dest_ff, result_ff}, {DEST_R1R0, mul_r[i]});
        end
        $display("multiply done");
        set_flags(8'h00);
        ef = 8'h15;
        epc = epc + 1'b1;
        go(OP_CMP, 8'h10, 8'h20, 1);
        chk("compare", {dest_ff, result_ff}, {DEST_NONE, 16'h0000});
        set_flags(8'h03);
        ef = 8'h02;
        epc = epc + 1'b1;
        go(OP_CMP_CARRY, 8'h21, 8'h20, 1);
        chk("compare", {dest_ff, result_ff}, {DEST_NONE, 16'h0000});
        $display("compare done");
        ins.koff = 7'h05;
        for (int i = 0; i < 6; i++) begin
            set_flags(br_f[i]);
            epc = epc + (br_tk[i] ? 22'h000006 : 22'h000001);
            go(br_op[i], 8'h00, 8'h00, br_tk[i] ? 2 : 1);
        end
        $display("branches done");
        set_flags(8'h3F);
        ins.io_byte = 8'h04;
        for (int i = 0; i < 6; i++) begin
            ins.bit_sel = sk_b[i][2:0];
            ins.next_two_word = sk_two[i];
            epc = epc + 22'(sk_d[i]);
            go(sk_op[i], sk_a[i], sk_b[i], sk_d[i]);
        end
        $display("skips done");
        set_flags(8'h00);
        ins.koff = 7'h40;
        epc = epc + 22'h3FFFC1;
        go(OP_BRANCH_SIGNED_GE, 8'h00, 8'h00, 2);
        ins.zptr = 16'hABCD;
        epc = 22'h00ABCD;
        go(OP_INDIRECT_JUMP_OP, 8'h00, 8'h00, 2);
        ins.zptr = 16'h0100;
        epc = 22'h000100;
        go(OP_INDIRECT_SUBROUTINE_CALL, 8'h00, 8'h00, 2);
        chk("call return", {push_seen, ret_addr_ff}, {1'b1, 22'h00ABCE});
        $display("indirect done");
        give_verdict();
    end
endmodule : test_cpu_alu_branch_exec

bind cpu_alu_branch_exec exec_assertions #(.PC_W(PC_W)) u_exec_assertions (
    .clk(clk), .rst(rst), .issue_valid(issue_valid), .issue(issue), .status_wr(status_wr),
    .busy_ff(busy_ff), .done_ff(done_ff), .dest_ff(dest_ff), .result_ff(result_ff),
    .status_flags_ff(status_flags_ff), .pc_ff(pc_ff)
);
`default_nettype wire
